// ===== hdl/switch_diag_map.vh
`ifndef SWITCH_DIAG_MAP_VH
`define SWITCH_DIAG_MAP_VH

// frame geometry
`define FRAME_BITS       5'd16
`define BYTE_BITS        5'd8
`define CNT_W            5
`define CMD_HI           15
`define CMD_LO           12

// command codes in bits 15..12
`define CMD_DIAG_PIN     4'h1
`define CMD_FAULT_READ   4'h2
`define READ_BANK_BIT    0

// diagnosis select field, bits 11..8, low two bits pick the register
`define SEL_HI           9
`define SEL_LO           8
`define SEL_BANK_ONE     2'h0
`define SEL_BANK_TWO     2'h1
`define SEL_BANK_THREE   2'h2

// pin-set byte fields
`define PIN_MODE_HI      3
`define PIN_MODE_LO      0
`define PIN_SW_HI        7
`define PIN_SW_LO        4
`define PIN_SET_RESET    8'h0F

// response frame, source select and synchroniser reset constants
`define READ_MARK        3'h1
`define BANK_TWO_ONES    2'h3
`define PAIR_NO_ERROR    2'h3
`define SRC_RESET        2'h2
`define SRC_SERIAL_BIT   1
`define SYNC_RESET       13'h1000

`endif

// ===== hdl/bit_sync.v
`default_nettype none

module bit_sync #(
  parameter             WIDTH = 1,
  parameter [WIDTH-1:0] RST   = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst_n,
  // asynchronous in, synchronous out
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_r;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_r <= RST;
      syncOut  <= RST;
    end
    else
    begin
      stage1_r <= asyncIn;
      syncOut  <= stage1_r;
    end
  end

endmodule // bit_sync

`default_nettype wire

// ===== hdl/fault_cell.v
`default_nettype none
`include "switch_diag_map.vh"

module fault_cell (
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // fault report from the power stage
  input  wire       faultEvent,
  input  wire [1:0] faultCode,
  // read-back clear
  input  wire       readClear,
  // stored pair
  output reg  [1:0] faultPair
);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      faultPair <= `PAIR_NO_ERROR;
    else if (faultEvent)
      faultPair <= faultCode;
    else if (readClear)
      faultPair <= `PAIR_NO_ERROR;
  end

endmodule // fault_cell

`default_nettype wire

// ===== hdl/switch_diag_frames.v
// Notes on behaviour
// - diag read frame: check bit, 001, six pairs (bank bit 1: 0000, four pairs)
// - pin frames answered during same transfer, read frames one frame later
// - first received byte picks second returned byte
// - second received byte shapes next frame's first
// - command 0001, select upper byte, pins lower
// - pin byte: low nibble mode, high nibble on/off
// - answer: feedback high byte, diagnosis low byte
// - diagnosis byte follows select, same frame
// - registers one and three hold four pairs
// - register two: pairs 6,5, ones, summaries
// - summary bit is NAND of its register
// - serial channels echo previous on/off bit
// - pin channels report pin level at select fall
// - feedback source chosen per channel
// - four serial on/off bits, channels 7 to 10
// - serial bit acts when source is 0x or 11
// - pair codes 11 ok,10,01,00; reset 11
// - diagnosis latched at select fall; newest wins
// - pin mode ignores serial bit for channel
`default_nettype none
`include "switch_diag_map.vh"

module switch_diag_frames #(
  parameter CHANNELS = 10
) (
  // clock and reset
  input  wire                  clk,
  input  wire                  rst_n,
  // serial link pins
  input  wire                  sclkPin,
  input  wire                  csPin_n,
  input  wire                  siPin,
  output reg                   soOut,
  output reg                   soOe,
  // direct control pins
  input  wire [CHANNELS-1:0]   directPin,
  // fault reports from the power stage
  input  wire [CHANNELS-1:0]   faultEvent,
  input  wire [2*CHANNELS-1:0] faultCode,
  // channel drive
  output reg  [CHANNELS-1:0]   channelOn
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_FRAME = 1'b1;

  // synchronised pins
  wire [CHANNELS+2:0]   syncBus;
  wire                  csnS;
  wire                  sclkS;
  wire                  siS;
  wire [CHANNELS-1:0]   pinS;

  // frame engine
  reg                   state_r;
  reg                   state_nxt;
  reg                   sclkPrev_r;
  reg                   csnPrev_r;
  reg  [`CNT_W-1:0]     bitCnt_r;
  reg  [15:0]           rxShift_r;
  reg  [15:0]           txShift_r;
  reg                   readPending_r;
  reg                   readBank_r;
  reg  [CHANNELS-1:0]   clearMask_r;

  // stored command state
  reg  [7:0]            pinSetWord_r;
  reg  [CHANNELS-1:0]   serialSwitchBits_r;
  reg  [2*CHANNELS-1:0] channelSourceSelect_r;

  // snapshots taken at select fall
  reg  [2*CHANNELS-1:0] faultSnap_r;

  wire [2*CHANNELS-1:0] channelFaultPair;
  wire                  sclkRise;
  wire                  sclkFall;
  wire                  csFall;
  wire                  csRise;
  wire                  frameDone;
  wire [3:0]            rxCmd;
  wire [1:0]            doSel;

  wire [7:0]            diagOutputBankOne;
  wire [7:0]            diagOutputBankTwo;
  wire [7:0]            diagOutputBankThree;
  wire                  bankOneAnyFault;
  wire                  bankThreeAnyFault;
  reg  [7:0]            diagOutByte;
  reg  [CHANNELS-1:0]   doClear;
  wire [7:0]            pinFeedbackByte;
  wire [11:0]           readField;
  wire [14:0]           readBody;
  wire [15:0]           readFrame;

  integer i;
  integer j;

  // pins cross into the clock domain through two stages
  bit_sync #(
    .WIDTH (CHANNELS+3),
    .RST   (`SYNC_RESET)
  ) u_pin_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({csPin_n, sclkPin, siPin, directPin}),
    .syncOut (syncBus)
  );

  assign csnS  = syncBus[CHANNELS+2];
  assign sclkS = syncBus[CHANNELS+1];
  assign siS   = syncBus[CHANNELS];
  assign pinS  = syncBus[CHANNELS-1:0];

  assign sclkRise  = sclkS & ~sclkPrev_r & ~csnS;
  assign sclkFall  = ~sclkS & sclkPrev_r & ~csnS;
  assign csFall    = csnPrev_r & ~csnS;
  assign csRise    = ~csnPrev_r & csnS;
  assign frameDone = csRise && (bitCnt_r == `FRAME_BITS);
  assign rxCmd     = rxShift_r[`CMD_HI:`CMD_LO];

  // per-channel fault storage, read back clears after a full frame
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1)
    begin : g_fault
      fault_cell u_fault (
        .clk        (clk),
        .rst_n      (rst_n),
        .faultEvent (faultEvent[g]),
        .faultCode  (faultCode[2*g+1:2*g]),
        .readClear  (frameDone & clearMask_r[g]),
        .faultPair  (channelFaultPair[2*g+1:2*g])
      );
    end
  endgenerate

  // diagnosis registers built from the select-fall snapshot
  assign diagOutputBankOne   = faultSnap_r[7:0];
  assign diagOutputBankThree = faultSnap_r[19:12];
  assign bankOneAnyFault     = ~&diagOutputBankOne;
  assign bankThreeAnyFault   = ~&diagOutputBankThree;
  assign diagOutputBankTwo   = {bankOneAnyFault, bankThreeAnyFault, `BANK_TWO_ONES, faultSnap_r[11:8]};

  // first received byte holds the select field
  assign doSel = rxShift_r[`SEL_HI-8:`SEL_LO-8];

  always @*
  begin
    diagOutByte = 8'h00;
    doClear     = {CHANNELS{1'b0}};
    if (rxShift_r[7:4] == `CMD_DIAG_PIN)
    begin
      case (doSel)
        `SEL_BANK_ONE:
        begin
          diagOutByte = diagOutputBankOne;
          doClear     = 10'h00F;
        end
        `SEL_BANK_TWO:
        begin
          diagOutByte = diagOutputBankTwo;
          doClear     = 10'h030;
        end
        `SEL_BANK_THREE:
        begin
          diagOutByte = diagOutputBankThree;
          doClear     = 10'h3C0;
        end
        default:
        begin
          diagOutByte = diagOutputBankOne;
          doClear     = 10'h00F;
        end
      endcase
    end
  end

  // feedback: serial channels echo, pin channels report sampled level
  genvar f;
  generate
    for (f = 0; f < 4; f = f + 1)
    begin : g_feedback
      // pin level read live, only used at the select fall that loads it
      assign pinFeedbackByte[`PIN_SW_LO+f] = pinSetWord_r[`PIN_MODE_LO+f] ? pinS[CHANNELS-4+f]
                                                                          : pinSetWord_r[`PIN_SW_LO+f];
    end
  endgenerate
  assign pinFeedbackByte[`PIN_MODE_HI:`PIN_MODE_LO] = pinSetWord_r[`PIN_MODE_HI:`PIN_MODE_LO];

  // diagnosis read frame with check bit, pairs as they stand at its own select fall
  assign readField = readBank_r ? {4'h0, channelFaultPair[19:12]} : channelFaultPair[11:0];
  assign readBody  = {`READ_MARK, readField};
  assign readFrame = {^readBody, readBody};

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (csFall)
          state_nxt = ST_FRAME;
      ST_FRAME:
        if (csnS)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // frame engine: sample on rising clock edge, shift out on falling
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r      <= ST_IDLE;
      sclkPrev_r   <= 1'b0;
      csnPrev_r    <= 1'b1;
      bitCnt_r     <= {`CNT_W{1'b0}};
      rxShift_r    <= 16'h0000;
      txShift_r    <= 16'h0000;
      faultSnap_r   <= {2*CHANNELS{1'b1}};
      readPending_r <= 1'b0;
      readBank_r    <= 1'b0;
      clearMask_r  <= {CHANNELS{1'b0}};
      soOut        <= 1'b0;
      soOe         <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      sclkPrev_r <= sclkS;
      csnPrev_r  <= csnS;
      soOe       <= ~csnS;
      soOut      <= txShift_r[15];
      if (csFall)
      begin
        faultSnap_r <= channelFaultPair;
        bitCnt_r    <= {`CNT_W{1'b0}};
        if (readPending_r)
        begin
          txShift_r   <= readFrame;
          clearMask_r <= readBank_r ? 10'h3C0 : 10'h03F;
        end
        else
        begin
          txShift_r   <= {pinFeedbackByte, 8'h00};
          clearMask_r <= {CHANNELS{1'b0}};
        end
      end
      else if (state_r == ST_FRAME)
      begin
        if (sclkRise)
        begin
          rxShift_r <= {rxShift_r[14:0], siS};
          if (bitCnt_r != `FRAME_BITS)
            bitCnt_r <= bitCnt_r + 1'b1;
        end
        else if (sclkFall)
        begin
          if (bitCnt_r == `BYTE_BITS && !readPending_r)
          begin
            txShift_r   <= {diagOutByte, 8'h00};
            clearMask_r <= doClear;
          end
          else
            txShift_r <= {txShift_r[14:0], 1'b0};
        end
      end
      if (frameDone)
      begin
        readPending_r <= (rxCmd == `CMD_FAULT_READ);
        if (rxCmd == `CMD_FAULT_READ)
          readBank_r <= rxShift_r[`READ_BANK_BIT];
      end
    end
  end

  // command decode at the end of a whole frame
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinSetWord_r          <= `PIN_SET_RESET;
      serialSwitchBits_r    <= {CHANNELS{1'b0}};
      channelSourceSelect_r <= {CHANNELS{`SRC_RESET}};
    end
    else if (frameDone && rxCmd == `CMD_DIAG_PIN)
    begin
      pinSetWord_r <= rxShift_r[7:0];
      for (i = 0; i < 4; i = i + 1)
      begin
        serialSwitchBits_r[6+i] <= rxShift_r[`PIN_SW_LO+i];
        channelSourceSelect_r[2*(6+i)+1] <= rxShift_r[`PIN_MODE_LO+i];
        channelSourceSelect_r[2*(6+i)]   <= 1'b0;
      end
    end
  end

  // channel drive follows the source select of each channel
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      channelOn <= {CHANNELS{1'b0}};
    else
    begin
      for (j = 0; j < CHANNELS; j = j + 1)
      begin
        if (!channelSourceSelect_r[2*j+`SRC_SERIAL_BIT])
          channelOn[j] <= serialSwitchBits_r[j];
        else if (!channelSourceSelect_r[2*j])
          channelOn[j] <= pinS[j];
        else
          channelOn[j] <= pinS[j] & serialSwitchBits_r[j];
      end
    end
  end

endmodule // switch_diag_frames

`default_nettype wire

// ===== testbench/switch_diag_frames_checker.sv
`default_nettype none

module switch_diag_frames_checker #(
  parameter CHANNELS = 10
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rst_n,
  // serial link pins
  input wire logic                  sclkPin,
  input wire logic                  csPin_n,
  input wire logic                  siPin,
  input wire logic                  soOut,
  input wire logic                  soOe,
  // channel side
  input wire logic [CHANNELS-1:0]   directPin,
  input wire logic [CHANNELS-1:0]   faultEvent,
  input wire logic [2*CHANNELS-1:0] faultCode,
  input wire logic [CHANNELS-1:0]   channelOn
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // select held low after its fall
  sequence selOpen;
    $fell(csPin_n) ##1 (!csPin_n)[*5];
  endsequence

  sequence selIdle;
    csPin_n[*5];
  endsequence

  // no frame ending and no pin change
  sequence quietSpan;
    ($stable(directPin) && csPin_n)[*8];
  endsequence

  a_oe_opens: assert property (selOpen |-> soOe)
    else $error("output enable missing in frame");
  a_oe_idle: assert property (selIdle |-> !soOe)
    else $error("output enable outside frame");
  a_oe_holds: assert property (soOe && !csPin_n |=> soOe)
    else $error("output enable dropped in frame");
  a_oe_drops: assert property ($rose(csPin_n) |-> ##[3:6] !soOe)
    else $error("output enable stuck after frame");
  a_so_steady: assert property ($rose(sclkPin) && soOe |=> $stable(soOut)[*6])
    else $error("serial out moved while sampled");
  a_leave_reset: assert property ($rose(rst_n) |-> (!soOe)[*3])
    else $error("output enable after reset");
  a_pin_follow: assert property ($stable(directPin)[*8] |-> channelOn[5:0] == directPin[5:0])
    else $error("pin channel not following pin");
  a_drive_hold: assert property (quietSpan |=> $stable(channelOn))
    else $error("channel drive changed without cause");
endmodule // switch_diag_frames_checker

bind switch_diag_frames switch_diag_frames_checker #(.CHANNELS(CHANNELS)) checkerInst (
  .clk(clk), .rst_n(rst_n), .sclkPin(sclkPin), .csPin_n(csPin_n), .siPin(siPin),
  .soOut(soOut), .soOe(soOe), .directPin(directPin), .faultEvent(faultEvent),
  .faultCode(faultCode), .channelOn(channelOn));

`default_nettype wire

// ===== testbench/spi_host_model.sv
`default_nettype none

module spi_host_model (
  // clock
  input  wire logic clk,
  // link pins
  output var  logic sclkPin,
  output var  logic csPin_n,
  output var  logic siPin,
  input  wire logic soOut
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclkPin = 1'b0;
    csPin_n = 1'b1;
    siPin   = 1'b0;
  end

  // data line is meaningless between frames
  always @(posedge clk)
    if (csPin_n)
      siPin <= ~siPin;

  // one 16-bit mode-0 frame, msb first, 160 ns link period
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    integer i;
    begin
      csPin_n <= 1'b0;
      repeat (8) @(posedge clk);
      for (i = 15; i >= 0; i--)
      begin
        siPin <= tx[i];
        repeat (8) @(posedge clk);
        rx[i] = soOut;
        sclkPin <= 1'b1;
        repeat (8) @(posedge clk);
        sclkPin <= 1'b0;
      end
      repeat (8) @(posedge clk);
      csPin_n <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
endmodule // spi_host_model

`default_nettype wire

// ===== testbench/switch_diag_frames_bench.sv
`default_nettype none

module switch_diag_frames_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_n;
  logic        sclkPin;
  logic        csPin_n;
  logic        siPin;
  logic        soOut;
  logic        soOe;
  logic [9:0]  directPin;
  logic [9:0]  faultEvent;
  logic [19:0] faultCode;
  logic [9:0]  channelOn;
  logic [15:0] rx;
  integer      err_count;
  integer      check_count;

  switch_diag_frames #(.CHANNELS(10)) uut (
    .clk(clk), .rst_n(rst_n), .sclkPin(sclkPin), .csPin_n(csPin_n), .siPin(siPin),
    .soOut(soOut), .soOe(soOe), .directPin(directPin), .faultEvent(faultEvent),
    .faultCode(faultCode), .channelOn(channelOn));

  spi_host_model host (
    .clk(clk), .sclkPin(sclkPin), .csPin_n(csPin_n), .siPin(siPin), .soOut(soOut));

  always #5 clk = ~clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      check_count++;
      if (got !== exp)
      begin
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        err_count++;
      end
    end
  endtask

  task automatic frame(input logic [15:0] tx, input logic [15:0] exp);
    begin
      host.xfer(tx, rx);
      chk(rx, exp);
    end
  endtask

  // one-cycle fault report on channel index k
  task automatic inject(input integer k, input logic [1:0] code);
    begin
      faultCode[2*k +: 2] <= code;
      faultEvent[k]       <= 1'b1;
      @(posedge clk);
      faultEvent <= 10'h000;
      @(posedge clk);
    end
  endtask

  task automatic print_verdict;
    begin
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  initial
  begin
    clk         = 1'b0;
    rst_n       = 1'b0;
    directPin   = 10'h2C5;
    faultEvent  = 10'h000;
    faultCode   = 20'hF_FFFF;
    err_count   = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    // pin mode feedback and first bank, no faults yet
    frame(16'h100F, 16'hBFFF);
    chk({6'h00, channelOn}, 16'h02C5);
    // mixed modes: ch8, ch10 serial on; ch7, ch9 by pin
    frame(16'h11A5, 16'hBF3F);
    directPin <= 10'h000;
    repeat (8) @(posedge clk);
    chk({6'h00, channelOn}, 16'h0280);
    frame(16'h120F, 16'hA5FF);
    repeat (8) @(posedge clk);
    chk({6'h00, channelOn}, 16'h0000);
    // overload on ch2, open load on ch9
    inject(1, 2'b10);
    inject(8, 2'b01);
    frame(16'h110F, 16'h0FFF);
    frame(16'h120F, 16'h0FDF);
    frame(16'h100F, 16'h0FFB);
    // whole-frame diagnosis reads, answered one frame later
    inject(4, 2'b00);
    inject(9, 2'b10);
    frame(16'h2000, 16'h0F00);
    frame(16'h2001, 16'h9CFF);
    frame(16'h0000, 16'h10BF);
    print_verdict();
  end
endmodule // switch_diag_frames_bench

`default_nettype wire
